//--- hw/rwu_top.sv
// reset sequencer and watchdog downcounter with wishbone registers
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "rwu_defines.svh"
module rwu_top
   import rwu_pkg::*;
#(
   parameter bit HW_ACTIVATION = 1'b0,
   parameter bit EXT_STOP_CTRL = 1'b0,
   parameter int RST_DELAY     = `RWU_RST_DELAY,
   parameter int PRESCALE      = `RWU_PRESCALE
) (
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        ext_rst_n,
   input  wire logic        por_n,
   input  wire logic        nmi_pin,
   input  wire logic        stop_exec,
   input  wire logic        wait_exec,
   input  wire logic        wake_irq,
   input  wire logic        return_from_interrupt_instr_exec,
   output logic             core_rst,
   output logic             io_pullup,
   output logic             osc_run,
   output logic             stack_clr,
   output logic             pc_load,
   output logic [11:0]      pc_vector,
   output logic             nmi_mode,
   output logic             wait_mode,
   output logic             stop_mode
);
   rwu_regs_t r_reg;
   rwu_regs_t r_next;
   logic      wdg_tick;

   // register view: bit 7 carries the period lsb, bit 2 the msb
   function automatic logic [5:0] rev6(input logic [5:0] v);
      logic [5:0] o;
      o = '0;
      for (int i = 0; i < 6; i++) begin
         o[i] = v[5 - i];
      end
      return o;
   endfunction

   // counter frozen only in true stop mode
   rwu_prescaler #(
      .DIV (PRESCALE)
   ) u_presc (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .run     (!r_reg.stop_mode),
      .tick    (wdg_tick)
   );

   always_comb begin
      logic       pin_low;
      logic       por_low;
      logic       nmi_high;
      logic       src;
      logic       wdg_fire;
      logic       sw_rst;
      logic       hit;
      logic       wr_wdg;
      logic [7:0] view;
      pin_low  = 1'b0;
      por_low  = 1'b0;
      nmi_high = 1'b0;
      src      = 1'b0;
      wdg_fire = 1'b0;
      sw_rst   = 1'b0;
      hit      = 1'b0;
      wr_wdg   = 1'b0;
      view     = 8'h00;
      r_next   = r_reg;

      // pins pass two flops before use
      r_next.meta = {nmi_pin, por_n, ext_rst_n};
      r_next.sync = r_reg.meta;
      pin_low  = !r_reg.sync[0];
      por_low  = !r_reg.sync[1];
      nmi_high = r_reg.sync[2];

      r_next.stack_clr = 1'b0;
      r_next.pc_load   = 1'b0;

      // bus access, one wait state, ack dropped the cycle after
      hit       = wb_cyc_i && wb_stb_i && !r_reg.ack;
      r_next.ack = hit;
      view = {rev6(r_reg.per), !r_reg.expired, r_reg.wdg_act};
      if (hit && !wb_we_i) begin
         unique case (wb_adr_i)
            `RWU_ADR_WDG:  r_next.dat = {24'h000000, view};
            `RWU_ADR_STAT: r_next.dat = {24'h000000, r_reg.nmi_mode,
                                         r_reg.stop_mode, r_reg.wait_mode,
                                         2'b00, r_reg.cause};
            default:       r_next.dat = 32'h00000000;
         endcase
      end
      // writes while the core is held in reset are ignored
      wr_wdg = hit && wb_we_i && wb_sel_i[0] && !r_reg.core_rst
               && wb_adr_i == `RWU_ADR_WDG;

      // watchdog countdown on the divided clock
      if (wdg_tick && !r_reg.expired && r_reg.state == RWU_RUN) begin
         if (r_reg.sub == 8'h00) begin
            r_next.sub = `RWU_SUB_MAX;
            if (r_reg.per == 6'h00) begin
               // trigger bit falls: 256 sub ticks per period step
               r_next.expired = 1'b1;
               wdg_fire       = r_reg.wdg_act;
            end else begin
               r_next.per = r_reg.per - 6'h01;
            end
         end else begin
            r_next.sub = r_reg.sub - 8'h01;
         end
      end

      if (wr_wdg) begin
         r_next.per     = rev6(wb_dat_i[`RWU_PER_HI:`RWU_PER_LO]);
         r_next.sub     = `RWU_SUB_MAX;
         r_next.expired = 1'b0;
         // activation is one-way until reset
         if (wb_dat_i[`RWU_BIT_C]) begin
            r_next.wdg_act = 1'b1;
         end
         sw_rst = !wb_dat_i[`RWU_BIT_SR];
      end
      if (HW_ACTIVATION) begin
         r_next.wdg_act = 1'b1;
      end

      // low power instructions
      if (r_reg.state == RWU_RUN) begin
         if (stop_exec) begin
            if (r_reg.wdg_act && !(EXT_STOP_CTRL && nmi_high)) begin
               r_next.wait_mode = 1'b1;
            end else begin
               r_next.stop_mode = 1'b1;
               r_next.osc_run   = 1'b0;
            end
         end else if (wait_exec) begin
            r_next.wait_mode = 1'b1;
         end
         if (wake_irq) begin
            r_next.wait_mode = 1'b0;
            r_next.stop_mode = 1'b0;
            r_next.osc_run   = 1'b1;
         end
         if (return_from_interrupt_instr_exec) begin
            r_next.nmi_mode = 1'b0;
         end
      end

      // any source, watchdog and software ones as a pulse
      src = pin_low || por_low || wdg_fire || sw_rst;
      if (pin_low || por_low || wdg_fire || sw_rst) begin
         r_next.cause = {wdg_fire || sw_rst, por_low, pin_low};
      end

      unique case (r_reg.state)
         RWU_HOLD: begin
            r_next.dly = '0;
            if (!src) begin
               r_next.state = RWU_DELAY;
            end
         end
         RWU_DELAY: begin
            if (src) begin
               r_next.state = RWU_HOLD;
            end else if (r_reg.dly == 12'(RST_DELAY - 1)) begin
               r_next.state    = RWU_INIT;
               r_next.core_rst = 1'b0;
            end else begin
               r_next.dly = r_reg.dly + 12'h001;
            end
         end
         RWU_INIT: begin
            r_next.stack_clr = 1'b1;
            r_next.pc_load   = 1'b1;
            r_next.pc_vec    = `RWU_RST_VECTOR;
            r_next.io_pullup = 1'b0;
            r_next.state     = src ? RWU_HOLD : RWU_RUN;
            r_next.core_rst  = src;
         end
         RWU_RUN: begin
            if (src) begin
               r_next.state = RWU_HOLD;
            end
         end
      endcase

      // every state but init and run keeps the core and watchdog in reset
      if (src || r_next.state != RWU_RUN && r_next.state != RWU_INIT) begin
         r_next.core_rst  = 1'b1;
         r_next.io_pullup = 1'b1;
         r_next.osc_run   = 1'b1;
         r_next.wait_mode = 1'b0;
         r_next.stop_mode = 1'b0;
         r_next.nmi_mode  = 1'b1;
         r_next.wdg_act   = HW_ACTIVATION;
         r_next.per       = '1;
         r_next.sub       = `RWU_SUB_MAX;
         r_next.expired   = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         r_reg           <= '0;
         r_reg.state     <= RWU_HOLD;
         r_reg.core_rst  <= 1'b1;
         r_reg.io_pullup <= 1'b1;
         r_reg.osc_run   <= 1'b1;
         r_reg.nmi_mode  <= 1'b1;
         r_reg.wdg_act   <= HW_ACTIVATION;
         r_reg.per       <= '1;
         r_reg.sub       <= `RWU_SUB_MAX;
         r_reg.pc_vec    <= `RWU_RST_VECTOR;
      end else begin
         r_reg <= r_next;
      end
   end

   assign wb_dat_o  = r_reg.dat;
   assign wb_ack_o  = r_reg.ack;
   assign core_rst  = r_reg.core_rst;
   assign io_pullup = r_reg.io_pullup;
   assign osc_run   = r_reg.osc_run;
   assign stack_clr = r_reg.stack_clr;
   assign pc_load   = r_reg.pc_load;
   assign pc_vector = r_reg.pc_vec;
   assign nmi_mode  = r_reg.nmi_mode;
   assign wait_mode = r_reg.wait_mode;
   assign stop_mode = r_reg.stop_mode;
endmodule

//--- hw/rwu_defines.svh
// constants of the reset and watchdog unit
`ifndef RWU_DEFINES_SVH
`define RWU_DEFINES_SVH
`define RWU_ADR_WDG     8'hd8
`define RWU_ADR_STAT    8'hdc
`define RWU_WDG_RST     8'hfe
`define RWU_BIT_C       0
`define RWU_BIT_SR      1
`define RWU_PER_LO      2
`define RWU_PER_HI      7
`define RWU_PER_W       6
`define RWU_SUB_MAX     8'hff
`define RWU_RST_DELAY   2048
`define RWU_DLY_W       12
`define RWU_PRESCALE    12
`define RWU_RST_VECTOR  12'hffe
`endif

//--- hw/rwu_pkg.sv
// types of the reset and watchdog unit
package rwu_pkg;
   typedef enum logic [3:0] {
      RWU_HOLD  = 4'b0001,
      RWU_DELAY = 4'b0010,
      RWU_INIT  = 4'b0100,
      RWU_RUN   = 4'b1000
   } rwu_state_t;

   typedef struct packed {
      logic [2:0]  meta;
      logic [2:0]  sync;
      rwu_state_t  state;
      logic [11:0] dly;
      logic        wdg_act;
      logic [5:0]  per;
      logic [7:0]  sub;
      logic        expired;
      logic        core_rst;
      logic        io_pullup;
      logic        osc_run;
      logic        stack_clr;
      logic        pc_load;
      logic [11:0] pc_vec;
      logic        nmi_mode;
      logic        wait_mode;
      logic        stop_mode;
      logic [2:0]  cause;
      logic        ack;
      logic [31:0] dat;
   } rwu_regs_t;
endpackage

//--- hw/rwu_prescaler.sv
// divide-by-n tick enable for the watchdog
`timescale 1ns/1ps
`include "rwu_defines.svh"
module rwu_prescaler #(
   parameter int DIV = `RWU_PRESCALE
) (
   input  wire logic ref_clk,
   input  wire logic sys_rst,
   input  wire logic run,
   output logic      tick
);
   logic [3:0] cnt_reg;
   logic [3:0] cnt_next;
   logic       tick_next;

   always_comb begin
      cnt_next  = cnt_reg;
      tick_next = 1'b0;
      // frozen divider keeps its phase while stopped
      if (run) begin
         if (cnt_reg == 4'(DIV - 1)) begin
            cnt_next  = 4'h0;
            tick_next = 1'b1;
         end else begin
            cnt_next = cnt_reg + 4'h1;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cnt_reg <= 4'h0;
         tick    <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         tick    <= tick_next;
      end
   end
endmodule

//--- tb/rwu_far_end.sv
// far-side model: reset circuit, supply monitor and nmi line
`timescale 1ns/1ps
module rwu_far_end (
   input  wire logic ref_clk,
   input  wire logic pin_req,
   input  wire logic pwr_bad,
   input  wire logic nmi_hold,
   output logic      ext_rst_n,
   output logic      por_n,
   output logic      nmi_pin
);
   // board logic moves just after the edge, never on it
   always_ff @(posedge ref_clk) begin
      ext_rst_n <= !pin_req;
      por_n     <= !pwr_bad;
   end
   // open-drain stop-control line: pull-up wins unless held low
   assign nmi_pin = nmi_hold ? 1'b0 : 1'b1;
endmodule

//--- tb/rwu_top_properties.sv
// port checker of the reset and watchdog unit
`timescale 1ns/1ps
module rwu_props #(
   parameter int RST_DELAY = 2048
) (
   input wire logic        ref_clk,
   input wire logic        sys_rst,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic        wb_ack_o,
   input wire logic        ext_rst_n,
   input wire logic        por_n,
   input wire logic        core_rst,
   input wire logic        io_pullup,
   input wire logic        osc_run,
   input wire logic        stack_clr,
   input wire logic        pc_load,
   input wire logic [11:0] pc_vector,
   input wire logic        nmi_mode,
   input wire logic        stop_mode
);
   logic [15:0] hi_cnt_reg;
   // cycles both sources read high; saturates so it never wraps
   always_ff @(posedge ref_clk) begin
      if (sys_rst || !ext_rst_n || !por_n) begin
         hi_cnt_reg <= 16'h0000;
      end else if (hi_cnt_reg != 16'hffff) begin
         hi_cnt_reg <= hi_cnt_reg + 16'h0001;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   property p_pin; !ext_rst_n [*5] |-> core_rst; endproperty
   a_pin: assert property (p_pin) else $error("pin low, core runs");
   property p_por; !por_n [*5] |-> core_rst && io_pullup; endproperty
   a_por: assert property (p_por) else $error("por low, core runs");
   property p_dly; $fell(core_rst) |-> hi_cnt_reg >= RST_DELAY; endproperty
   a_dly: assert property (p_dly) else $error("release too early");
   property p_init;
      $fell(core_rst) |-> ##[0:1] (stack_clr && pc_load
         && pc_vector == 12'hffe);
   endproperty
   a_init: assert property (p_init) else $error("no vector load");
   property p_pull; core_rst [*2] |-> io_pullup && osc_run; endproperty
   a_pull: assert property (p_pull) else $error("bad reset pins");
   property p_nmi; $fell(core_rst) |-> nmi_mode; endproperty
   a_nmi: assert property (p_nmi) else $error("not in nmi context");
   property p_stop; stop_mode |-> !osc_run; endproperty
   a_stop: assert property (p_stop) else $error("osc runs in stop");
   property p_swr;
      wb_ack_o && wb_we_i && wb_adr_i == 8'hd8 && wb_sel_i[0]
         && !wb_dat_i[1] && !$past(core_rst) |-> ##[0:2] core_rst;
   endproperty
   a_swr: assert property (p_swr) else $error("no software reset");
   cover property ($fell(core_rst));
   cover property ($rose(stop_mode));
   cover property (wb_ack_o && wb_we_i);
endmodule
bind rwu_top rwu_props #(.RST_DELAY(RST_DELAY)) i_rwu_props (
   .ref_clk(ref_clk), .sys_rst(sys_rst), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_ack_o(wb_ack_o), .ext_rst_n(ext_rst_n), .por_n(por_n),
   .core_rst(core_rst), .io_pullup(io_pullup), .osc_run(osc_run),
   .stack_clr(stack_clr), .pc_load(pc_load), .pc_vector(pc_vector),
   .nmi_mode(nmi_mode), .stop_mode(stop_mode));

//--- tb/tb_top.sv
// self-checking bench of the reset and watchdog unit
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin \
   num_errors++; $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module tb_top;
   localparam int DLY = 8;
   localparam int PS  = 2;
   logic        ref_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
   logic [7:0]  adr = 8'h00, rdat;
   logic [3:0]  sel = 4'h0;
   logic [31:0] wdat = 32'h0, dat_o;
   logic        pin_req = 1'b0, pwr_bad = 1'b0, nmi_hold = 1'b0;
   logic        stop_x = 1'b0, wait_x = 1'b0, wake = 1'b0, return_from_interrupt_instr = 1'b0;
   logic        ext_rst_n, por_n, nmi_pin, core_rst, io_pullup, osc_run;
   logic        stack_clr, pc_load, nmi_mode, wait_mode, stop_mode;
   logic [11:0] pc_vector;
   int          num_errors = 0, n_tests = 0;
   always #12.5 ref_clk = ~ref_clk;
   rwu_far_end i_rwu_far_end (.ref_clk(ref_clk), .pin_req(pin_req),
      .pwr_bad(pwr_bad), .nmi_hold(nmi_hold), .ext_rst_n(ext_rst_n),
      .por_n(por_n), .nmi_pin(nmi_pin));
   rwu_top #(.HW_ACTIVATION(1'b0), .EXT_STOP_CTRL(1'b1), .RST_DELAY(DLY),
      .PRESCALE(PS)) i_rwu_top (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .ext_rst_n(ext_rst_n), .por_n(por_n), .nmi_pin(nmi_pin),
      .stop_exec(stop_x), .wait_exec(wait_x), .wake_irq(wake),
      .return_from_interrupt_instr_exec(return_from_interrupt_instr), .core_rst(core_rst), .io_pullup(io_pullup),
      .osc_run(osc_run), .stack_clr(stack_clr), .pc_load(pc_load),
      .pc_vector(pc_vector), .nmi_mode(nmi_mode), .wait_mode(wait_mode),
      .stop_mode(stop_mode));
   task automatic conclude();
      if (num_errors == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // request stands until ack is sampled, then drops for a cycle
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [7:0] d);
      @(posedge ref_clk);
      {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, 4'h1, 24'h0, d};
      // no local limit: only the bench watchdog ends a lost answer
      do begin
         @(posedge ref_clk);
      end while (ack !== 1'b1);
      rdat = dat_o[7:0];
      {cyc, stb} <= 2'b00;
   endtask
   task automatic wait_rst(input logic lv, output int n);
      n = 0;
      while (core_rst !== lv) begin
         @(posedge ref_clk);
         n++;
      end
   endtask
   // one-cycle pulse of stop, wake or return from interrupt
   task automatic hit(input logic [2:0] v);
      @(posedge ref_clk);
      {stop_x, wake, return_from_interrupt_instr} <= v;
      @(posedge ref_clk);
      {stop_x, wake, return_from_interrupt_instr} <= 3'b000;
      repeat (3) @(posedge ref_clk);
   endtask
   task automatic t_regs();
      wb(1'b0, 8'hd8, 8'h00);
      `CHK("wdg_reg", 8'hfe, rdat);
      `CHK("ports_freed", 1'b0, io_pullup);
      wb(1'b1, 8'h10, 8'h55);
      wb(1'b0, 8'h10, 8'h00);
      `CHK("unmapped", 8'h00, rdat);
      hit(3'b001);
      `CHK("nmi_left", 1'b0, nmi_mode);
   endtask
   task automatic t_src(input logic por, input int len);
      int m, n;
      wait_x <= 1'b1;
      @(posedge ref_clk);
      wait_x <= 1'b0;
      @(posedge ref_clk);
      `CHK("in_wait", 1'b1, wait_mode);
      if (por) pwr_bad <= 1'b1;
      else pin_req <= 1'b1;
      repeat (len) @(posedge ref_clk);
      if (len > 5) begin
         `CHK("held", 3'b110, {core_rst, io_pullup, wait_mode});
      end
      {pin_req, pwr_bad} <= 2'b00;
      wait_rst(1'b1, m);
      wait_rst(1'b0, n);
      m = m + n;
      `CHK("release", 1'b1, m >= DLY + 2 && m <= DLY + 6);
      `CHK("nmi_mode", 1'b1, nmi_mode);
   endtask
   task automatic t_swrst();
      int n;
      wb(1'b1, 8'hd8, 8'hfc);
      wait_rst(1'b1, n);
      `CHK("sw_reset", 1'b1, n < 4);
      wait_rst(1'b0, n);
      wb(1'b0, 8'hd8, 8'h00);
      `CHK("wdg_after_sw", 8'hfe, rdat);
      wb(1'b0, 8'hdc, 8'h00);
      `CHK("status", 8'h84, rdat);
   endtask
   task automatic t_stop();
      int n;
      hit(3'b100);
      `CHK("stop_plain", 2'b10, {stop_mode, osc_run});
      hit(3'b010);
      `CHK("woken", 1'b0, stop_mode);
      nmi_hold <= 1'b1;
      wb(1'b1, 8'hd8, 8'h03);
      hit(3'b100);
      `CHK("as_wait", 3'b011, {stop_mode, wait_mode, osc_run});
      hit(3'b010);
      nmi_hold <= 1'b0;
      wb(1'b1, 8'hd8, 8'h03);
      hit(3'b100);
      repeat (1500) @(posedge ref_clk);
      `CHK("frozen", 2'b10, {stop_mode, core_rst});
      hit(3'b010);
      wait_rst(1'b1, n);
      `CHK("resumed", 1'b1, n < 600);
      wait_rst(1'b0, n);
   endtask
   task automatic t_wdg();
      int n;
      wb(1'b1, 8'hd8, 8'h03);
      repeat (3) begin
         repeat (400) @(posedge ref_clk);
         wb(1'b1, 8'hd8, 8'h03);
      end
      `CHK("reloaded", 1'b0, core_rst);
      wb(1'b1, 8'hd8, 8'h82);
      wait_rst(1'b1, n);
      `CHK("period_1", 1'b1, n > 1016 && n < 1032);
      wait_rst(1'b0, n);
      wb(1'b1, 8'hd8, 8'hff);
      wait_rst(1'b1, n);
      `CHK("period_63", 1'b1, n > 32760 && n < 32776);
      wait_rst(1'b0, n);
      wb(1'b0, 8'hd8, 8'h00);
      `CHK("wdg_reinit", 8'hfe, rdat);
   endtask
   initial begin
      int n;
      repeat (8) @(posedge ref_clk);
      sys_rst <= 1'b0;
      wait_rst(1'b0, n);
      `CHK("start_nmi", 1'b1, nmi_mode);
      t_regs();
      t_src(1'b0, 2);
      t_src(1'b0, 10);
      t_src(1'b1, 10);
      t_swrst();
      t_stop();
      t_wdg();
      conclude();
   end
   // run needs about 40000 cycles; this cuts a hang short
   initial begin
      repeat (60000) @(posedge ref_clk);
      num_errors++;
      conclude();
   end
endmodule
